// ==== hw/lcf_cycle_timer.sv ====
/*
 Isochronous cycle timer: offset, cycle number and seconds fields,
 advanced by a 24.576 MHz tick made from the system clock.
 Assumes all inputs synchronous to i_clk_sys.
*/
`timescale 1ns/1ps
`include "lcf_map.svh"
module lcf_cycle_timer
(
   input  wire logic                i_clk_sys,
   input  wire logic                i_nrst,
   input  wire logic                i_run,
   input  wire logic                i_ext_mode,
   input  wire logic                i_ext_event,
   input  wire logic                i_load,
   input  wire lcf_pkg::lcf_word_type i_load_val,
   output lcf_pkg::lcf_word_type    o_timer,
   output logic                     o_rollover
);
   // Fractional divider; 50 MHz has no integer ratio to 24.576 MHz
   lcf_pkg::lcf_acc_type acc_reg;
   lcf_pkg::lcf_acc_type acc_sum;
   lcf_pkg::lcf_acc_type acc_next;
   logic                 tick;
   lcf_pkg::lcf_ofs_type ofs_reg;
   lcf_pkg::lcf_cnt_type cnt_reg;
   lcf_pkg::lcf_sec_type sec_reg;
   logic                 ofs_last;
   logic                 cnt_last;
   logic                 ext_step;
   logic                 int_step;
   logic                 step;

   assign acc_sum  = acc_reg + `LCF_ACC_W'(`LCF_TB_KHZ);
   assign tick     = acc_sum >= `LCF_ACC_W'(`LCF_SYS_KHZ);
   assign acc_next = tick ? acc_sum - `LCF_ACC_W'(`LCF_SYS_KHZ) : acc_sum;
   assign ofs_last = ofs_reg == `LCF_OFS_LAST;
   assign cnt_last = cnt_reg == `LCF_CNT_LAST;
   assign ext_step = i_run & i_ext_mode & i_ext_event;
   assign int_step = i_run & ~i_ext_mode & tick & ofs_last;
   assign step     = ext_step | int_step;

   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         acc_reg    <= '0;
         ofs_reg    <= '0;
         cnt_reg    <= '0;
         sec_reg    <= '0;
         o_rollover <= 1'b0;
      end
      else
      begin
         acc_reg    <= acc_next;
         o_rollover <= step & ~i_load;
         if (i_load)
         begin
            ofs_reg <= i_load_val[`LCF_OFS_W-1:0];
            cnt_reg <= i_load_val[`LCF_OFS_W+`LCF_CNT_W-1:`LCF_OFS_W];
            sec_reg <= i_load_val[31:`LCF_OFS_W+`LCF_CNT_W];
         end
         else if (step)
         begin
            ofs_reg <= '0;
            cnt_reg <= cnt_last ? '0 : cnt_reg + 1'b1;
            if (cnt_last)
               sec_reg <= sec_reg + 1'b1;
         end
         else if (i_run & tick & ~ofs_last)
            ofs_reg <= ofs_reg + 1'b1;
         // Offset parks at its last value awaiting the external event
      end
   end

   assign o_timer = {sec_reg, cnt_reg, ofs_reg};
endmodule

// ==== hw/lcf_map.svh ====
/*
 Register offsets, bit positions, field widths and timing constants
 for the link control and fairness register block.
 Assumes a 50 MHz system clock and a 24.576 MHz cycle timebase.
*/
`ifndef LCF_MAP_SVH
`define LCF_MAP_SVH
`define LCF_OFS_FAIR  8'hdc
`define LCF_OFS_SET   8'he0
`define LCF_OFS_CLR   8'he4
`define LCF_BIT_SRC   22
`define LCF_BIT_MST   21
`define LCF_BIT_RUN   20
`define LCF_BIT_PHY   10
`define LCF_BIT_SID   9
`define LCF_CFG_MASK  32'h0070_0600
`define LCF_CFG_RST   32'h0000_0000
`define LCF_SRC_KEEP  32'h0040_0000
`define LCF_FAIR_W    8
`define LCF_FAIR_RST  8'h00
`define LCF_OFS_W     12
`define LCF_CNT_W     13
`define LCF_SEC_W     7
`define LCF_OFS_LAST  12'hbff
`define LCF_CNT_LAST  13'h1f3f
`define LCF_SYS_KHZ   50000
`define LCF_TB_KHZ    24576
`define LCF_ACC_W     17
`endif

// ==== hw/lcf_pkg.sv ====
/*
 Shared types of the link control and fairness register block.
 Assumes lcf_map.svh supplies the field widths.
*/
`include "lcf_map.svh"
package lcf_pkg;
   typedef logic [31:0]               lcf_word_type;
   typedef logic [`LCF_FAIR_W-1:0]    lcf_fair_type;
   typedef logic [`LCF_OFS_W-1:0]     lcf_ofs_type;
   typedef logic [`LCF_CNT_W-1:0]     lcf_cnt_type;
   typedef logic [`LCF_SEC_W-1:0]     lcf_sec_type;
   typedef logic [`LCF_ACC_W-1:0]     lcf_acc_type;
endpackage

// ==== hw/lcf_regs.sv ====
/*
 Link control and fairness registers of a serial bus link layer,
 with priority request budgeting, cycle master control and receive
 packet gating.
 Assumes a host register port synchronous to i_clk_sys and a link
 core that reports events as one-cycle pulses.
*/
// Operation
// - Link config has a set address and a clear address; ones act.
// - Reads at either link config address return the same contents.
// - Priority requests per fairness interval never exceed the limit field.
// - Limit of zero means no priority requests at all.
// - External source: cycle number advances only on the external event.
// - Offset returns to zero whenever the cycle number increments.
// - External source: offset holds at 3071 until the event arrives.
// - Internal source: timer rolls over every 3072 timebase clocks.
// - External source bit acts only while cycle master is set.
// - Hardware reset clears external source; software reset keeps it.
// - Master and root: send cycle start on each rollover.
// - Not master: accept received cycle starts for synchronisation.
// - Overrun clears master; master cannot be set while overrun flagged.
// - Timer enable runs offset counting; otherwise the offset freezes.
// - PHY packet bit with async receive context on admits PHY packets.
// - PHY bit never gates in-phase self-ID or bus reset packets.
// - Self-ID receive bit admits self-ID packets into the buffer.
// - Timer is 12 offset, 13 cycle number, 7 seconds bits.
// - Not master: load timer from cycle start; else free-run.
`timescale 1ns/1ps
`include "lcf_map.svh"
module lcf_regs
#(
   parameter int FAIR_W = `LCF_FAIR_W
)
(
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_nrst,
   input  wire logic                  i_soft_rst,
   input  wire logic                  i_reg_wr,
   input  wire logic                  i_reg_rd,
   input  wire logic [7:0]            i_reg_addr,
   input  wire lcf_pkg::lcf_word_type i_reg_wdata,
   output lcf_pkg::lcf_word_type      o_reg_rdata,
   output logic                       o_reg_ack,
   input  wire logic                  i_fair_interval,
   input  wire logic                  i_pri_req,
   output logic                       o_pri_grant,
   input  wire logic                  i_is_root,
   input  wire logic                  i_ext_cycle_event,
   input  wire logic                  i_overrun_event,
   input  wire logic                  i_overrun_flag,
   input  wire logic                  i_cs_rx_valid,
   input  wire lcf_pkg::lcf_word_type i_cs_rx_data,
   output logic                       o_cs_tx,
   output lcf_pkg::lcf_word_type      o_cs_tx_data,
   output lcf_pkg::lcf_word_type      o_cycle_timer,
   output logic                       o_cycle_master,
   input  wire logic                  i_async_receive_en,
   input  wire logic                  i_rx_phy_pkt,
   input  wire logic                  i_rx_self_id_pkt,
   input  wire logic                  i_rx_bus_reset_pkt,
   input  wire logic                  i_self_id_phase,
   output logic                       o_async_receive_put,
   output logic                       o_self_id_put
);
   generate
      if (FAIR_W != `LCF_FAIR_W)
      begin : g_bad_width
         $error("lcf_regs: FAIR_W must match the limit field");
      end
   endgenerate

   // Register state
   lcf_pkg::lcf_word_type  cfg_reg;
   lcf_pkg::lcf_word_type  cfg_next;
   logic [FAIR_W-1:0]      fair_reg;
   logic [FAIR_W-1:0]      fair_next;
   logic [FAIR_W-1:0]      pri_cnt_reg;
   logic [FAIR_W-1:0]      pri_cnt_next;

   // Address decode
   logic                   hit_fair;
   logic                   hit_set;
   logic                   hit_clr;
   logic                   wr_fair;
   lcf_pkg::lcf_word_type  set_bits;
   lcf_pkg::lcf_word_type  clr_bits;
   lcf_pkg::lcf_word_type  cfg_sw;
   lcf_pkg::lcf_word_type  cfg_hw;
   lcf_pkg::lcf_word_type  rd_word;

   // Control bits
   logic                   ext_src;
   logic                   master;
   logic                   timer_run;
   logic                   phy_en;
   logic                   sid_en;
   logic                   ext_mode;
   logic                   ts_load;

   // Fairness budget
   logic                   pri_room;
   logic                   pri_ok;

   // Receive gating
   logic                   sid_in_phase;
   logic                   sid_out_phase;
   logic                   ar_phy_take;
   logic                   ar_bus_rst_take;
   logic                   ar_take;
   logic                   sid_take;

   // Cycle timer link
   lcf_pkg::lcf_word_type  timer_val;
   logic                   rollover;
   logic                   cs_send;

   assign hit_fair = i_reg_addr == `LCF_OFS_FAIR;
   assign hit_set  = i_reg_addr == `LCF_OFS_SET;
   assign hit_clr  = i_reg_addr == `LCF_OFS_CLR;
   assign wr_fair  = i_reg_wr & hit_fair;

   // Only the implemented bits can ever be stored
   assign set_bits = (i_reg_wr & hit_set) ? i_reg_wdata & `LCF_CFG_MASK : '0;
   assign clr_bits = (i_reg_wr & hit_clr) ? i_reg_wdata & `LCF_CFG_MASK : '0;
   assign cfg_sw   = (cfg_reg | set_bits) & ~clr_bits;

   // Hardware keeps master low during and after an overrun
   always_comb
   begin
      cfg_hw = cfg_sw;
      if (i_overrun_flag & ~cfg_reg[`LCF_BIT_MST])
         cfg_hw[`LCF_BIT_MST] = 1'b0;
      if (i_overrun_event)
         cfg_hw[`LCF_BIT_MST] = 1'b0;
   end

   // Software reset spares the source selection only
   assign cfg_next = i_soft_rst ? cfg_reg & `LCF_SRC_KEEP : cfg_hw;

   assign fair_next = wr_fair ? i_reg_wdata[FAIR_W-1:0] : fair_reg;

   assign ext_src   = cfg_reg[`LCF_BIT_SRC];
   assign master    = cfg_reg[`LCF_BIT_MST];
   assign timer_run = cfg_reg[`LCF_BIT_RUN];
   assign phy_en    = cfg_reg[`LCF_BIT_PHY];
   assign sid_en    = cfg_reg[`LCF_BIT_SID];

   // Source bit is meaningless unless this node is cycle master
   assign ext_mode = ext_src & master;

   // Slave nodes follow the sender of cycle starts
   assign ts_load = i_cs_rx_valid & ~master;

   // Cycle start goes out only from a root cycle master
   assign cs_send = rollover & master & i_is_root;

   // Zero limit leaves no room, the plain arbitration behaviour
   assign pri_room = pri_cnt_reg < fair_reg;
   assign pri_ok   = i_pri_req & pri_room & ~i_fair_interval;

   always_comb
   begin
      pri_cnt_next = pri_cnt_reg;
      if (i_fair_interval)
         pri_cnt_next = '0;
      else if (pri_ok)
         pri_cnt_next = pri_cnt_reg + 1'b1;
   end

   // Self-ID outside its phase counts as an ordinary PHY packet
   assign sid_in_phase    = i_rx_self_id_pkt & i_self_id_phase;
   assign sid_out_phase   = i_rx_self_id_pkt & ~i_self_id_phase;
   assign ar_phy_take     = (i_rx_phy_pkt | sid_out_phase) & phy_en;
   assign ar_bus_rst_take = i_rx_bus_reset_pkt;
   assign ar_take         = i_async_receive_en & (ar_phy_take | ar_bus_rst_take);
   assign sid_take        = sid_in_phase & sid_en;

   // Both link config addresses return the same word
   always_comb
   begin
      rd_word = '0;
      if (hit_fair)
         rd_word = {{(32-FAIR_W){1'b0}}, fair_reg};
      else if (hit_set | hit_clr)
         rd_word = cfg_reg & `LCF_CFG_MASK;
   end

   lcf_cycle_timer u_timer
   (
      .i_clk_sys   (i_clk_sys),
      .i_nrst      (i_nrst),
      .i_run       (timer_run),
      .i_ext_mode  (ext_mode),
      .i_ext_event (i_ext_cycle_event),
      .i_load      (ts_load),
      .i_load_val  (i_cs_rx_data),
      .o_timer     (timer_val),
      .o_rollover  (rollover)
   );

   assign o_cycle_timer = timer_val;

   // Hardware reset clears every control bit, source among them
   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         cfg_reg  <= `LCF_CFG_RST;
         fair_reg <= `LCF_FAIR_RST;
      end
      else
      begin
         cfg_reg  <= cfg_next;
         fair_reg <= fair_next;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
         pri_cnt_reg <= '0;
      else
         pri_cnt_reg <= pri_cnt_next;
   end

   // Read answer lands one cycle after the strobe
   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_reg_rdata <= '0;
         o_reg_ack   <= 1'b0;
      end
      else
      begin
         o_reg_ack <= i_reg_rd | i_reg_wr;
         if (i_reg_rd)
            o_reg_rdata <= rd_word;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
         o_pri_grant <= 1'b0;
      else
         o_pri_grant <= pri_ok;
   end

   // Payload is the timer value just after the rollover, offset zero
   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_cs_tx      <= 1'b0;
         o_cs_tx_data <= '0;
      end
      else
      begin
         o_cs_tx <= cs_send;
         if (cs_send)
            o_cs_tx_data <= timer_val;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
         o_cycle_master <= 1'b0;
      else
         o_cycle_master <= cfg_next[`LCF_BIT_MST];
   end

   // One-cycle accept strobes toward the receive contexts
   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_async_receive_put <= 1'b0;
         o_self_id_put       <= 1'b0;
      end
      else
      begin
         o_async_receive_put <= ar_take;
         o_self_id_put       <= sid_take;
      end
   end
endmodule

// ==== tb/lcf_phy_model.sv ====
/* Physical layer stand-in: interval, timing event and cycle start pulses.
 Assumes requests from the bench, one cycle each. */
`timescale 1ns/1ps
module lcf_phy_model
(
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_nrst,
   input  wire logic [2:0]            i_fire,
   input  wire lcf_pkg::lcf_word_type i_cs_val,
   output logic                       o_fair_interval,
   output logic                       o_ext_event,
   output logic                       o_cs_valid,
   output lcf_pkg::lcf_word_type      o_cs_data
);
   always_ff @(posedge i_clk_sys or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_fair_interval <= 1'b0;
         o_ext_event     <= 1'b0;
         o_cs_valid      <= 1'b0;
         o_cs_data       <= 32'h0000_0000;
      end
      else
      begin
         o_fair_interval <= i_fire[0];
         o_ext_event     <= i_fire[1];
         o_cs_valid      <= i_fire[2];
         // Idle data toggles so stale values never look valid
         o_cs_data       <= i_fire[2] ? i_cs_val : ~o_cs_data;
      end
   end
endmodule

// ==== tb/lcf_regs_sva.sv ====
/* Port assertions for lcf_regs.
 Assumes one clock domain; bound to lcf_regs below. */
`timescale 1ns/1ps
module lcf_regs_sva
(
   input wire logic                  i_clk_sys,
   input wire logic                  i_nrst,
   input wire logic                  i_reg_wr,
   input wire logic                  i_reg_rd,
   input wire logic                  o_reg_ack,
   input wire logic                  i_pri_req,
   input wire logic                  o_pri_grant,
   input wire logic                  i_is_root,
   input wire logic                  i_overrun_event,
   input wire logic                  i_overrun_flag,
   input wire logic                  o_cycle_master,
   input wire logic                  o_cs_tx,
   input wire lcf_pkg::lcf_word_type o_cs_tx_data,
   input wire lcf_pkg::lcf_word_type o_cycle_timer,
   input wire logic                  i_cs_rx_valid,
   input wire logic                  i_async_receive_en,
   input wire logic                  i_rx_bus_reset_pkt,
   input wire logic                  i_rx_self_id_pkt,
   input wire logic                  i_self_id_phase,
   input wire logic                  o_self_id_put,
   input wire logic                  o_async_receive_put
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   a_ack_follows: assert property ((i_reg_wr || i_reg_rd) |=> o_reg_ack)
      else $error("ack missing");
   a_grant_needs_req: assert property (!i_pri_req |=> !o_pri_grant)
      else $error("grant without request");
   a_overrun_stop: assert property (i_overrun_event |=> !o_cycle_master)
      else $error("master kept after overrun");
   a_flag_blocks: assert property (!o_cycle_master && i_overrun_flag |=> !o_cycle_master)
      else $error("master set while flagged");
   a_tx_ofs_zero: assert property (o_cs_tx |-> o_cs_tx_data[11:0] == 12'h000)
      else $error("cycle start offset not zero");
   a_tx_master_root: assert property (o_cs_tx |-> $past(o_cycle_master) && $past(i_is_root))
      else $error("cycle start without master and root");
   a_ofs_cap: assert property (o_cycle_timer[11:0] <= 12'hbff)
      else $error("offset above 3071");
   // Besides a return to zero, load from a received cycle start is the only jump allowed
   a_ofs_step: assert property ($changed(o_cycle_timer[11:0]) && !$past(i_cs_rx_valid)
      |-> o_cycle_timer[11:0] == $past(o_cycle_timer[11:0]) + 12'h001 || o_cycle_timer[11:0] == 12'h000)
      else $error("offset jumped");
   a_sid_phase: assert property (i_rx_self_id_pkt && !i_self_id_phase |=> !o_self_id_put)
      else $error("self id taken outside phase");
   a_ctx_gate: assert property (!i_async_receive_en |=> !o_async_receive_put)
      else $error("put with context off");
   a_bus_reset: assert property (i_rx_bus_reset_pkt && i_async_receive_en |=> o_async_receive_put)
      else $error("bus reset packet dropped");
   cover property (o_cs_tx);
   cover property (o_pri_grant);
   cover property (o_self_id_put);
endmodule

bind lcf_regs lcf_regs_sva u_lcf_regs_sva (.i_clk_sys, .i_nrst, .i_reg_wr, .i_reg_rd, .o_reg_ack, .i_pri_req,
   .o_pri_grant, .i_is_root, .i_overrun_event, .i_overrun_flag, .o_cycle_master, .o_cs_tx, .o_cs_tx_data,
   .o_cycle_timer, .i_cs_rx_valid, .i_async_receive_en, .i_rx_bus_reset_pkt, .i_rx_self_id_pkt,
   .i_self_id_phase, .o_self_id_put, .o_async_receive_put);

// ==== tb/tb.sv ====
/* Self-checking bench for lcf_regs.
 Assumes lcf_phy_model as the far side. */
`timescale 1ns/1ps
module tb;
   logic i_clk_sys = 1'b0, i_nrst = 1'b0, i_soft_rst = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_pri_req = 1'b0;
   logic i_is_root = 1'b0, i_overrun_event = 1'b0, i_overrun_flag = 1'b0, i_async_receive_en = 1'b0;
   logic i_rx_phy_pkt = 1'b0, i_rx_self_id_pkt = 1'b0, i_rx_bus_reset_pkt = 1'b0, i_self_id_phase = 1'b0;
   logic [7:0] i_reg_addr = 8'h00;
   logic [2:0] fire = 3'h0;
   logic [6:0] r;
   lcf_pkg::lcf_word_type i_reg_wdata = '0, i_cs_val = '0, o_reg_rdata, o_cs_tx_data, o_cycle_timer, i_cs_rx_data, v;
   logic o_reg_ack, o_pri_grant, o_cs_tx, o_cycle_master, o_async_receive_put, o_self_id_put;
   logic i_fair_interval, i_ext_cycle_event, i_cs_rx_valid;
   int miscompares = 0, samples_checked = 0, seed = 32'hf5f4, n_gr = 0, n_tx = 0, t, g0, lim;
   lcf_regs u_lcf_regs (.i_clk_sys, .i_nrst, .i_soft_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
      .o_reg_rdata, .o_reg_ack, .i_fair_interval, .i_pri_req, .o_pri_grant, .i_is_root, .i_ext_cycle_event,
      .i_overrun_event, .i_overrun_flag, .i_cs_rx_valid, .i_cs_rx_data, .o_cs_tx, .o_cs_tx_data, .o_cycle_timer,
      .o_cycle_master, .i_async_receive_en, .i_rx_phy_pkt, .i_rx_self_id_pkt, .i_rx_bus_reset_pkt,
      .i_self_id_phase, .o_async_receive_put, .o_self_id_put);
   lcf_phy_model u_lcf_phy_model (.i_clk_sys, .i_nrst, .i_fire(fire), .i_cs_val, .o_fair_interval(i_fair_interval),
      .o_ext_event(i_ext_cycle_event), .o_cs_valid(i_cs_rx_valid), .o_cs_data(i_cs_rx_data));
   always #10 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys)
   begin
      n_gr = n_gr + int'(o_pri_grant === 1'b1);
      n_tx = n_tx + int'(o_cs_tx === 1'b1);
   end
   task automatic chk(input string what, input lcf_pkg::lcf_word_type exp, got);
      samples_checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input lcf_pkg::lcf_word_type d);
      i_reg_wr <= w;
      i_reg_rd <= !w;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_clk_sys);
      i_reg_wr <= 1'b0;
      i_reg_rd <= 1'b0;
      @(posedge i_clk_sys);
      chk("ack", 32'h1, {31'h0, o_reg_ack});
   endtask
   task automatic rd_chk(input logic [7:0] a, input lcf_pkg::lcf_word_type e);
      acc(1'b0, a, '0);
      chk("rdata", e, o_reg_rdata);
   endtask
   task automatic pulse(input int k);
      fire <= 3'(1 << k);
      @(posedge i_clk_sys);
      fire <= 3'h0;
   endtask
   // Bounded wait for the cycle number to move
   task automatic wait_cnt(output int t);
      v = o_cycle_timer;
      t = 0;
      while (o_cycle_timer[24:12] === v[24:12] && t < 7000)
      begin
         @(posedge i_clk_sys);
         t++;
      end
      chk("ofs at step", 32'h0, {20'h0, o_cycle_timer[11:0]});
   endtask
   // Timer value just after one external step: offset zero, cycle number wraps at 7999
   function automatic lcf_pkg::lcf_word_type nxt(input lcf_pkg::lcf_word_type w);
      if (w[24:12] == 13'h1f3f)
         return {w[31:25] + 7'h01, 13'h0000, 12'h000};
      return {w[31:25], w[24:12] + 13'h0001, 12'h000};
   endfunction
   function automatic logic [1:0] exp_put(input logic [6:0] q);
      return {q[0] & (q[3] | (q[5] & (q[1] | (q[2] & !q[4])))), q[2] & q[4] & q[6]};
   endfunction
   task automatic give_verdict;
      if (miscompares == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      @(posedge i_clk_sys);
      rd_chk(8'he0, 32'h0);
      acc(1'b1, 8'he0, 32'hffff_ffff);
      rd_chk(8'he4, 32'h0070_0600);
      acc(1'b1, 8'he4, 32'h0000_0400);
      acc(1'b1, 8'he0, 32'h0);
      rd_chk(8'he0, 32'h0070_0200);
      rd_chk(8'he8, 32'h0);
      i_soft_rst <= 1'b1;
      @(posedge i_clk_sys);
      i_soft_rst <= 1'b0;
      rd_chk(8'he4, 32'h0040_0000);
      acc(1'b1, 8'he0, 32'h0010_0000);
      wait_cnt(t);
      wait_cnt(t);
      chk("period", 32'd6250, t);
      v = {7'($random(seed)), 13'({$random(seed)} % 8000), 12'({$random(seed)} % 3000)};
      i_cs_val <= v;
      pulse(2);
      repeat (2) @(posedge i_clk_sys);
      chk("loaded", {12'h0, v[31:12]}, {12'h0, o_cycle_timer[31:12]});
      chk("load ofs", 32'h1, {31'h0, o_cycle_timer[11:0] - v[11:0] < 12'h3});
      acc(1'b1, 8'he4, 32'h0010_0000);
      v = o_cycle_timer;
      repeat (100) @(posedge i_clk_sys);
      chk("frozen", v, o_cycle_timer);
      i_is_root <= 1'b1;
      acc(1'b1, 8'he0, 32'h0070_0000);
      for (t = 0; t < 6400 && o_cycle_timer[11:0] !== 12'hbff; t++)
         @(posedge i_clk_sys);
      g0 = n_tx;
      repeat (50) @(posedge i_clk_sys);
      chk("hold", 32'hbff, {20'h0, o_cycle_timer[11:0]});
      chk("no start", g0, n_tx);
      v = o_cycle_timer;
      pulse(1);
      repeat (4) @(posedge i_clk_sys);
      chk("start sent", g0 + 1, n_tx);
      chk("start data", nxt(v), o_cs_tx_data);
      chk("ofs small", 32'h1, {31'h0, o_cycle_timer[11:0] < 12'h8});
      i_overrun_event <= 1'b1;
      @(posedge i_clk_sys);
      i_overrun_event <= 1'b0;
      i_overrun_flag <= 1'b1;
      rd_chk(8'he0, 32'h0050_0000);
      acc(1'b1, 8'he0, 32'h0020_0000);
      rd_chk(8'he0, 32'h0050_0000);
      chk("master", 32'h0, {31'h0, o_cycle_master});
      i_overrun_flag <= 1'b0;
      // Mid-run hardware reset must drop the source bit that soft reset keeps
      i_nrst <= 1'b0;
      @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      @(posedge i_clk_sys);
      rd_chk(8'he0, 32'h0);
      for (int k = 0; k < 4; k++)
      begin
         lim = (k == 0) ? 0 : {$random(seed)} % 6;
         acc(1'b1, 8'hdc, 32'hffff_ff00 | 32'(lim));
         rd_chk(8'hdc, 32'(lim));
         g0 = n_gr;
         pulse(0);
         i_pri_req <= 1'b1;
         repeat (10) @(posedge i_clk_sys);
         i_pri_req <= 1'b0;
         repeat (2) @(posedge i_clk_sys);
         chk("grants", 32'(lim), n_gr - g0);
      end
      for (int i = 0; i < 16; i++)
      begin
         r = (i == 0) ? 7'h09 : 7'($random(seed));
         acc(1'b1, 8'he4, 32'h0000_0600);
         acc(1'b1, 8'he0, {21'h0, r[5], r[6], 9'h0});
         {i_self_id_phase, i_rx_bus_reset_pkt, i_rx_self_id_pkt, i_rx_phy_pkt, i_async_receive_en} <= r[4:0];
         @(posedge i_clk_sys);
         {i_rx_bus_reset_pkt, i_rx_self_id_pkt, i_rx_phy_pkt} <= 3'h0;
         @(posedge i_clk_sys);
         chk("puts", exp_put(r), {o_async_receive_put, o_self_id_put});
      end
      give_verdict;
   end
   initial
   begin
      repeat (60000) @(posedge i_clk_sys);
      miscompares++;
      give_verdict;
   end
endmodule
